// *** logic/fault_pkg.sv ***
// Shared constants for the supply fault detect and filter block
package fault_pkg;
	localparam int channel_count = 10;
	localparam int dedicated_count = 5;
	localparam int dual_count = 5;
	localparam int code_width = 8;
	localparam int hyst_width = 5;
	localparam int sample_width = 8;
	localparam logic [7:0] code_full_scale = 8'hff;
	localparam logic [4:0] hyst_max = 5'h1f;
	// Comparator mode codes
	localparam logic [1:0] mode_low_limit = 2'h0;
	localparam logic [1:0] mode_high_limit = 2'h1;
	localparam logic [1:0] mode_window = 2'h2;
	// Range select codes, ranges as printed (millivolts)
	localparam logic [1:0] range_sel_0 = 2'h0;
	localparam logic [1:0] range_sel_1 = 2'h1;
	localparam logic [1:0] range_sel_2 = 2'h2;
	localparam logic [1:0] range_sel_3 = 2'h3;
	localparam int range0_bottom_mv = 573;
	localparam int range0_span_mv = 802;
	localparam int range1_bottom_mv = 1250;
	localparam int range1_span_mv = 1750;
	localparam int range2_bottom_mv = 2500;
	localparam int range2_span_mv = 3500;
	localparam int range3_bottom_mv = 6000;
	localparam int range3_span_mv = 9600;
	// Clock and internal tick
	localparam int mclk_hz = 40000000;
	localparam int tick_hz = 100000;
	localparam int tick_div = mclk_hz / tick_hz;
	localparam int tick_div_width = 9;
	// Filter and pulse widths, in microseconds and ticks
	localparam int filter_max_us = 100;
	localparam int pulse_max_us = 100;
	localparam int tick_us = 1000000 / tick_hz;
	localparam int filter_max_ticks = filter_max_us / tick_us;
	localparam int count_width = 4;
	localparam int pullup_weak_ua = 10;
	// Reset values
	localparam logic [9:0] reset_flags = 10'h000;
	localparam logic [3:0] reset_count = 4'h0;
endpackage : fault_pkg

// *** logic/timing_if.sv ***
// Interface carrying the shared timing tick between block modules
`timescale 1ns/1ps
interface timing_if;
	logic tick;
	modport source (output tick);
	modport sink (input tick);
endinterface : timing_if

// *** logic/glitch_filter.sv ***
// Tick-timed glitch filter for one comparator or logic input
`timescale 1ns/1ps
module glitch_filter (
	input wire logic mclk,
	input wire logic rstn,
	timing_if.sink tm,
	input wire logic [3:0] timeout,
	input wire logic raw,
	output logic filt
);
	logic [4:0] count_q;
	logic pend_q;

	// Output takes the input once it has stood unchanged for timeout ticks
	// One spare tick absorbs the tick phase, so a pulse shorter than the
	// timeout can never pass; the price is up to one tick of extra lag
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_q <= {1'b0, fault_pkg::reset_count};
			filt <= 1'b0;
			pend_q <= 1'b0;
		end else if (raw == filt) begin
			count_q <= {1'b0, fault_pkg::reset_count}; // R23
			pend_q <= 1'b0;
		end else if (timeout == 4'h0) begin
			filt <= raw;
		end else if (!pend_q) begin
			pend_q <= 1'b1;
			count_q <= {1'b0, timeout} + 5'h01; // R23
		end else if (tm.tick) begin
			if (count_q == 5'h01) begin
				filt <= raw; // R12
				pend_q <= 1'b0;
			end
			count_q <= count_q - 5'h01;
		end
	end

	short_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
		(raw != filt) && pend_q && (count_q > 5'h01) |=> filt == $past(filt))
		else $error("filter passed a short pulse"); // R11
endmodule : glitch_filter

// *** logic/edge_pulse.sv ***
// Level or edge shaping of one filtered logic input
`timescale 1ns/1ps
module edge_pulse (
	input wire logic mclk,
	input wire logic rstn,
	timing_if.sink tm,
	input wire logic edge_mode,
	input wire logic [3:0] width,
	input wire logic level,
	output logic shaped
);
	logic prev_q;
	logic [3:0] left_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			left_q <= fault_pkg::reset_count;
		end else if (prev_q != level) begin
			left_q <= width; // R23
		end else if (tm.tick && left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			shaped <= 1'b0;
		end else if (!edge_mode) begin
			shaped <= level; // R18
		end else begin
			// Width zero masks a count left over from an earlier width
			shaped <= (left_q != 4'h0) && (width != 4'h0); // R19 R24
		end
	end

	zero_width_a: assert property (@(posedge mclk) disable iff (!rstn)
		edge_mode && width == 4'h0 |=> !shaped)
		else $error("zero width produced a pulse"); // R24
endmodule : edge_pulse

// *** logic/supply_fault_detect_filter.sv ***
// Supply fault detectors, dual-function logic inputs and warning merge
// Contract
// R1 - Ten inputs: five dedicated detectors, five dual-function channels.
// R2 - A dual channel is either analog detector or logic input, never both.
// R3 - Each detector flags low-limit, high-limit or window faults.
// R4 - Thresholds are 8-bit codes, linear over the selected range.
// R5 - Four ranges; high-voltage input upper two, positive inputs lower three.
// R6 - Dual channels in analog use support only the lowest range.
// R7 - Comparators evaluate continuously, every clock.
// R8 - Hysteresis is a 5-bit code, span times code over 255.
// R9 - Active low-limit fault clears above threshold plus hysteresis.
// R10 - Active high-limit fault clears below threshold minus hysteresis.
// R11 - Pulses shorter than the filter timeout never reach the output.
// R12 - Longer pulses pass, delayed exactly by the timeout; the code delays them by the timeout plus up to one tick.
// R13 - Dual channel as logic input makes a warning detector on its pair.
// R14 - Warning detector uses paired input range and reports warnings.
// R15 - Warnings readable as status and ORed into one warning.
// R16 - Logic-input results go to the output state machine.
// R17 - Each logic input selects level or edge detection.
// R18 - Level mode output is a buffered copy of the input.
// R19 - Edge mode emits one programmable-width pulse per transition.
// R20 - Logic inputs share the same glitch filter.
// R21 - Logic inputs have a selectable weak pull-down.
// R22 - An internal 100 kHz clock is generated.
// R23 - Timeouts and widths count internal ticks, restart on toggles.
// R24 - Edge mode with zero width never pulses.
`timescale 1ns/1ps
module supply_fault_detect_filter (
	input wire logic mclk,
	input wire logic rstn,
	// Digitised input levels, channel 0-3 positive, 4 high-voltage, 5-9 dual
	input wire logic [79:0] sample_levels,
	input wire logic [79:0] low_threshold,
	input wire logic [79:0] high_threshold,
	input wire logic [49:0] hysteresis_code,
	input wire logic [19:0] fault_mode,
	input wire logic [19:0] range_select,
	input wire logic [39:0] filter_timeout,
	// Dual channel role: 1 = logic input
	input wire logic [4:0] dual_is_logic,
	input wire logic [4:0] dual_logic_pins,
	input wire logic [4:0] edge_mode,
	input wire logic [19:0] pulse_width,
	input wire logic [4:0] pulldown_select,
	output logic [9:0] fault_status,
	output logic [4:0] warning_status,
	output logic any_warning,
	output logic [4:0] logic_results,
	output logic [4:0] pulldown_enable,
	output logic [9:0] range_effective,
	output logic internal_clock
);
	timing_if tm ();

	logic [8:0] div_q;
	logic tick_q;
	logic clk_q;
	logic [9:0] low_act_q;
	logic [9:0] high_act_q;
	logic [9:0] raw_fault;
	logic [9:0] filt_fault;
	logic [4:0] filt_logic;
	logic [4:0] shaped;
	logic [1:0] range_fix [9:0];

	assign tm.tick = tick_q;

	// Tick every 10 us; internal clock toggles each 5 us
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div_q <= 9'h000;
			tick_q <= 1'b0;
			clk_q <= 1'b0;
		end else if (div_q == 9'(fault_pkg::tick_div - 1)) begin
			div_q <= 9'h000;
			tick_q <= 1'b1; // R22
			clk_q <= ~clk_q;
		end else begin
			div_q <= div_q + 9'h001;
			tick_q <= 1'b0;
			if (div_q == 9'(fault_pkg::tick_div / 2 - 1)) begin
				clk_q <= ~clk_q; // R22
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			internal_clock <= 1'b0;
		end else begin
			internal_clock <= clk_q;
		end
	end

	// Allowed range per channel; illegal picks clamp to nearest legal
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			range_fix[i] = range_select[2*i +: 2];
			if (i < 4) begin
				if (range_fix[i] == fault_pkg::range_sel_3) begin
					range_fix[i] = fault_pkg::range_sel_2; // R5
				end
			end else if (i == 4) begin
				if (range_fix[i] < fault_pkg::range_sel_2) begin
					range_fix[i] = fault_pkg::range_sel_2; // R5
				end
			end else if (dual_is_logic[i-5]) begin
				// Warning detector follows its paired primary range
				range_fix[i] = range_select[2*(i-5) +: 2]; // R14
				if (i - 5 < 4 && range_fix[i] == fault_pkg::range_sel_3) begin
					range_fix[i] = fault_pkg::range_sel_2;
				end
				if (i == 9 && range_fix[i] < fault_pkg::range_sel_2) begin
					range_fix[i] = fault_pkg::range_sel_2;
				end
			end else begin
				range_fix[i] = fault_pkg::range_sel_0; // R6
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			range_effective <= fault_pkg::reset_flags;
		end else begin
			for (int i = 0; i < 10; i++) begin
				range_effective[i] <= (range_fix[i] != range_select[2*i +: 2]);
			end
		end
	end

	// Comparators with hysteresis, evaluated each clock
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			low_act_q <= fault_pkg::reset_flags;
			high_act_q <= fault_pkg::reset_flags;
		end else begin
			for (int i = 0; i < 10; i++) begin
				logic [8:0] v;
				logic [8:0] lo;
				logic [8:0] hi;
				logic [8:0] hy;
				v = {1'b0, sample_levels[8*i +: 8]};
				lo = {1'b0, low_threshold[8*i +: 8]}; // R4
				hi = {1'b0, high_threshold[8*i +: 8]}; // R4
				hy = {4'h0, hysteresis_code[5*i +: 5]}; // R8
				if (!low_act_q[i]) begin
					low_act_q[i] <= v < lo; // R7
				end else begin
					low_act_q[i] <= v <= lo + hy; // R9
				end
				if (!high_act_q[i]) begin
					high_act_q[i] <= v > hi; // R7
				end else begin
					high_act_q[i] <= v + hy >= hi; // R10
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 10; i++) begin
			case (fault_mode[2*i +: 2])
				fault_pkg::mode_low_limit: raw_fault[i] = low_act_q[i]; // R3
				fault_pkg::mode_high_limit: raw_fault[i] = high_act_q[i];
				default: raw_fault[i] = low_act_q[i] | high_act_q[i];
			endcase
		end
	end

	// One filter per channel for faults, one per dual pin for logic
	for (genvar g = 0; g < 10; g++) begin : fault_filters
		glitch_filter u_filt (
			.mclk(mclk),
			.rstn(rstn),
			.tm(tm),
			.timeout(filter_timeout[4*g +: 4]),
			.raw(raw_fault[g]),
			.filt(filt_fault[g])
		); // R11 R12
	end

	for (genvar g = 0; g < 5; g++) begin : logic_chans
		glitch_filter u_filt (
			.mclk(mclk),
			.rstn(rstn),
			.tm(tm),
			.timeout(filter_timeout[4*(g+5) +: 4]),
			.raw(dual_logic_pins[g] & dual_is_logic[g]),
			.filt(filt_logic[g])
		); // R20
		edge_pulse u_shape (
			.mclk(mclk),
			.rstn(rstn),
			.tm(tm),
			.edge_mode(edge_mode[g]),
			.width(pulse_width[4*g +: 4]),
			.level(filt_logic[g]),
			.shaped(shaped[g])
		); // R17
	end

	// Status and results: a dual channel reports in exactly one role
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fault_status <= fault_pkg::reset_flags;
			warning_status <= 5'h00;
			any_warning <= 1'b0;
			logic_results <= 5'h00;
			pulldown_enable <= 5'h00;
		end else begin
			fault_status[4:0] <= filt_fault[4:0]; // R1
			fault_status[9:5] <= filt_fault[9:5] & ~dual_is_logic; // R2
			warning_status <= filt_fault[9:5] & dual_is_logic; // R13 R15
			any_warning <= |(filt_fault[9:5] & dual_is_logic); // R15
			logic_results <= shaped & dual_is_logic; // R16 R2
			pulldown_enable <= pulldown_select & dual_is_logic; // R21
		end
	end

	warn_merge_a: assert property (@(posedge mclk) disable iff (!rstn)
		##1 any_warning == (|warning_status))
		else $error("warning merge mismatch"); // R15
	role_excl_a: assert property (@(posedge mclk) disable iff (!rstn)
		((logic_results | warning_status) & fault_status[9:5]) == 5'h00)
		else $error("dual channel in two roles"); // R2
	low_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
		low_act_q[0] && sample_levels[7:0] <= low_threshold[7:0]
		|=> low_act_q[0])
		else $error("low fault cleared too soon"); // R9
	high_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
		high_act_q[0] && sample_levels[7:0] >= high_threshold[7:0]
		|=> high_act_q[0])
		else $error("high fault cleared too soon"); // R10
	tick_rate_a: assert property (@(posedge mclk) disable iff (!rstn)
		tick_q |=> !tick_q [*8])
		else $error("tick too frequent"); // R22
	level_copy_a: assert property (@(posedge mclk) disable iff (!rstn)
		!edge_mode[0] |=> ##1 logic_results[0]
		== ($past(filt_logic[0], 2) & $past(dual_is_logic[0])))
		else $error("level mode not a copy"); // R18
	range_dual_a: assert property (@(posedge mclk) disable iff (!rstn)
		!dual_is_logic[0] |-> range_fix[5] == fault_pkg::range_sel_0)
		else $error("dual analog range wrong"); // R6
	low_set_a: assert property (@(posedge mclk) disable iff (!rstn)
		!low_act_q[1] && sample_levels[15:8] < low_threshold[15:8]
		|=> low_act_q[1])
		else $error("low fault missed"); // R7
endmodule : supply_fault_detect_filter

// *** testbench/supply_model.sv ***
// Far-side model: supply comparator levels and logic input pins
`timescale 1ns/1ps
module supply_model (
	input wire logic mclk,
	input wire logic [79:0] level_set,
	input wire logic [4:0] pin_set,
	output logic [79:0] sample_levels,
	output logic [4:0] dual_logic_pins
);
	initial begin
		sample_levels = 80'h0;
		dual_logic_pins = 5'h0;
	end
	// Far side moves just after the falling edge, clear of the bench's
	// own update at that edge and of the design's sampling edge
	always @(negedge mclk) begin
		#1;
		sample_levels <= level_set;
		dual_logic_pins <= pin_set;
	end
endmodule : supply_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the supply fault detect and filter block
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [79:0] lv = {10{8'h90}}, samp, lo = 80'h0, hi = 80'h0;
	logic [49:0] hy = 50'h0;
	logic [19:0] fm = 20'h0, rs = 20'h0, pw = 20'h0;
	logic [39:0] ft = 40'h0;
	logic [4:0] dil = 5'h0, pin = 5'h0, pins, em = 5'h0, pds = 5'h0;
	logic [9:0] fs, reff;
	logic [4:0] ws, lr, pde;
	logic aw, iclk, bad;
	int error_cnt = 0;
	int num_checks = 0;
	int n;
	always #12.5 mclk = ~mclk;
	supply_model far (.mclk(mclk), .level_set(lv), .pin_set(pin),
		.sample_levels(samp), .dual_logic_pins(pins));
	supply_fault_detect_filter dut (.mclk(mclk), .rstn(rstn),
		.sample_levels(samp), .low_threshold(lo), .high_threshold(hi),
		.hysteresis_code(hy), .fault_mode(fm), .range_select(rs),
		.filter_timeout(ft), .dual_is_logic(dil), .dual_logic_pins(pins),
		.edge_mode(em), .pulse_width(pw), .pulldown_select(pds),
		.fault_status(fs), .warning_status(ws), .any_warning(aw),
		.logic_results(lr), .pulldown_enable(pde),
		.range_effective(reff), .internal_clock(iclk));
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t exp %h got %h", $time, exp, got);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask : cyc
	task automatic s_range;
		chk(32'h0, {fs, ws, aw, lr, pde});
		cyc(2);
		chk(32'h1, reff[4]);
		chk(32'h0, reff[0]);
		rs[3:2] = 2'h3;
		rs[11:10] = 2'h3;
		cyc(4);
		chk(32'h1, reff[1]);
		chk(32'h1, reff[5]);
	endtask : s_range
	task automatic s_low;
		lo[7:0] = 8'h80;
		hy[4:0] = 5'h04;
		lv[7:0] = 8'h7f;
		cyc(2);
		chk(32'h0, fs[0]);
		cyc(1);
		chk(32'h1, fs[0]);
		lv[7:0] = 8'h83;
		cyc(5);
		chk(32'h1, fs[0]);
		lv[7:0] = 8'h85;
		cyc(5);
		chk(32'h0, fs[0]);
	endtask : s_low
	task automatic s_high;
		lv[15:8] = 8'h30;
		hi[15:8] = 8'h40;
		hy[9:5] = 5'h03;
		fm[3:2] = 2'h1;
		cyc(5);
		chk(32'h0, fs[1]);
		lv[15:8] = 8'h41;
		cyc(5);
		chk(32'h1, fs[1]);
		lv[15:8] = 8'h3e;
		cyc(5);
		chk(32'h1, fs[1]);
		lv[15:8] = 8'h3c;
		cyc(5);
		chk(32'h0, fs[1]);
	endtask : s_high
	task automatic s_window;
		lo[23:16] = 8'h20;
		hi[23:16] = 8'h60;
		fm[5:4] = 2'h2;
		lv[23:16] = 8'h40;
		cyc(5);
		chk(32'h0, fs[2]);
		lv[23:16] = 8'h70;
		cyc(5);
		chk(32'h1, fs[2]);
		lv[23:16] = 8'h10;
		cyc(5);
		chk(32'h1, fs[2]);
		lv[23:16] = 8'h40;
		cyc(5);
		chk(32'h0, fs[2]);
	endtask : s_window
	task automatic s_glitch;
		// Two ticks of timeout; the pulse below is one and a half ticks
		ft[15:12] = 4'h2;
		lo[31:24] = 8'h80;
		cyc(5);
		lv[31:24] = 8'h00;
		cyc(600);
		lv[31:24] = 8'h90;
		bad = fs[3];
		repeat (1500) begin
			cyc(1);
			bad = bad | fs[3];
		end
		chk(32'h0, bad);
		lv[31:24] = 8'h00;
		cyc(350);
		chk(32'h0, fs[3]);
		cyc(900);
		chk(32'h1, fs[3]);
		lv[31:24] = 8'h90;
		cyc(1300);
		chk(32'h0, fs[3]);
	endtask : s_glitch
	task automatic s_logic;
		dil[0] = 1'b1;
		pds[0] = 1'b1;
		lo[47:40] = 8'h80;
		lv[47:40] = 8'h00;
		pin[0] = 1'b1;
		cyc(6);
		chk(32'h1, lr[0]);
		chk(32'h1, pde[0]);
		chk(32'h0, fs[5]);
		chk(32'h1, ws[0]);
		chk(32'h1, aw);
		pin[0] = 1'b0;
		lv[47:40] = 8'h90;
		cyc(6);
		chk(32'h0, lr[0]);
		chk(32'h0, aw);
	endtask : s_logic
	task automatic s_edge;
		em[0] = 1'b1;
		pw[3:0] = 4'h2;
		cyc(2);
		pin[0] = 1'b1;
		n = 0;
		while (lr[0] !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		if (n == 100) begin
			error_cnt++;
			print_verdict();
		end
		n = 0;
		while (lr[0] === 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		chk(32'h1, n >= 400 && n <= 1200);
		pw[3:0] = 4'h0;
		pin[0] = 1'b0;
		bad = 1'b0;
		repeat (1300) begin
			cyc(1);
			bad = bad | lr[0];
		end
		chk(32'h0, bad);
	endtask : s_edge
	task automatic s_clock;
		n = 0;
		repeat (4000) begin
			@(posedge iclk or negedge mclk);
			if (iclk === 1'b1 && mclk === 1'b1) n++;
		end
		chk(32'h1, n >= 9 && n <= 11);
	endtask : s_clock
	initial begin
		#1000000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		cyc(3);
		rstn = 1'b1;
		s_range();
		s_low();
		s_high();
		s_window();
		s_glitch();
		s_logic();
		s_edge();
		s_clock();
		print_verdict();
	end
endmodule : tb_top
